// *** inc/dmac_defs.svh ***
// register map, control field positions and lane widths of the multiply-accumulate block
`ifndef DMAC_DEFS_SVH
`define DMAC_DEFS_SVH

// register word addresses on the software port
`define DMAC_ADDR_W        4
`define DMAC_CTRL_ADDR     4'h0
`define DMAC_RES_LO_ADDR   4'h4
`define DMAC_RES_HI_ADDR   4'h8

// control register fields and reset value
`define DMAC_CTRL_W        10
`define DMAC_CTRL_RESET    10'h000
`define DMAC_MODE_LSB      0
`define DMAC_SIGNED_BIT    2
`define DMAC_ADD_BIT       3
`define DMAC_SUB_BIT       4
`define DMAC_ACC_BIT       5
`define DMAC_SHIFT_LSB     6

// operand and result widths
`define DMAC_A_W           19
`define DMAC_B_W           18
`define DMAC_R_W           48
`define DMAC_DUAL_R_W      24
`define DMAC_QUAD_R_W      12
`define DMAC_LANES         4

`endif

// *** inc/dmac_pkg.sv ***
// types shared by the multiply-accumulate block and its lanes
`default_nettype none
package dmac_pkg;

   // operating mode of the whole block
   typedef enum logic [1:0] {
      DMAC_NORMAL,
      DMAC_DUAL,
      DMAC_QUAD,
      DMAC_FLOAT
   } dmac_mode_t;

   // one full-width lane result
   typedef logic [47:0] dmac_word_t;

endpackage : dmac_pkg
`default_nettype wire

// *** inc/dmac_lane_if.sv ***
// connection between the block top and one integer lane
`timescale 1ns/1ps
`default_nettype none
interface dmac_lane_if;
   import dmac_pkg::*;
   logic [18:0] a_raw;      // a field, lane lsb at bit 0
   logic [17:0] b_raw;      // b field, lane lsb at bit 0
   dmac_word_t  c_raw;      // addend field
   dmac_word_t  acc;        // registered lane result
   logic [4:0]  aw;         // a field width
   logic [4:0]  bw;         // b field width
   logic [5:0]  rw;         // result width, zero when idle
   logic        is_signed;  // shared sign selection
   logic        use_add;    // product goes to adder
   logic        sub;        // subtract instead of add
   logic        accum;      // add to own result
   logic [3:0]  shift;      // right shift amount
   dmac_word_t  next_acc;   // next lane result
   dmac_word_t  shifted;    // shifted lane output

   modport top (output a_raw, b_raw, c_raw, acc, aw, bw, rw, is_signed, use_add, sub, accum, shift,
                input next_acc, shifted);
   modport lane (input a_raw, b_raw, c_raw, acc, aw, bw, rw, is_signed, use_add, sub, accum, shift,
                 output next_acc, shifted);
endinterface : dmac_lane_if
`default_nettype wire

// *** hdl/dmac_lane.sv ***
// one integer multiply, add or subtract lane with right shifter
`timescale 1ns/1ps
`default_nettype none
module dmac_lane
   import dmac_pkg::*;
(
   dmac_lane_if.lane lp
);
   logic [18:0]        a_x;   // extended a operand
   logic [17:0]        b_x;   // extended b operand
   logic               a_top; // sign bit of a field
   logic               b_top; // sign bit of b field
   logic               r_top; // sign bit of result field
   logic signed [38:0] p_s;   // raw product
   dmac_word_t         mask;  // result width mask
   dmac_word_t         prod;  // product at full width
   dmac_word_t         base;  // addend or previous result
   dmac_word_t         sum;   // masked adder output
   dmac_word_t         ext;   // sum extended for shifting

   // extend fields by the shared sign setting, then multiply
   always_comb begin
      a_top = 1'b0;
      b_top = 1'b0;
      for (int i = 0; i < 19; i++) begin
         if (5'(i + 1) == lp.aw) a_top = lp.a_raw[i];
      end
      for (int i = 0; i < 18; i++) begin
         if (5'(i + 1) == lp.bw) b_top = lp.b_raw[i];
      end
      for (int i = 0; i < 19; i++) begin
         a_x[i] = (5'(i) < lp.aw) ? lp.a_raw[i] : (lp.is_signed & a_top);
      end
      for (int i = 0; i < 18; i++) begin
         b_x[i] = (5'(i) < lp.bw) ? lp.b_raw[i] : (lp.is_signed & b_top);
      end
      p_s  = $signed({lp.is_signed & a_x[18], a_x}) * $signed({lp.is_signed & b_x[17], b_x});
      prod = {{9{p_s[38]}}, p_s};
   end

   // adder or subtractor, optional accumulation, wrap at lane width
   always_comb begin
      for (int i = 0; i < 48; i++) begin
         mask[i] = 6'(i) < lp.rw;
      end
      base = (lp.accum ? lp.acc : lp.c_raw) & mask;
      if (!lp.use_add) begin
         sum = prod & mask;
      end else if (lp.sub) begin
         sum = (base - prod) & mask;
      end else begin
         sum = (base + prod) & mask;
      end
      r_top = 1'b0;
      for (int i = 0; i < 48; i++) begin
         if (6'(i + 1) == lp.rw) r_top = sum[i];
         ext[i] = mask[i] ? sum[i] : (lp.is_signed & r_top);
      end
   end

   // lane result and its right shifted copy
   assign lp.next_acc = sum;
   assign lp.shifted  = (lp.is_signed ? dmac_word_t'($signed(ext) >>> lp.shift)
                                      : (ext >> lp.shift)) & mask;

endmodule : dmac_lane
`default_nettype wire

// *** hdl/dmac_top.sv ***
// multiply-accumulate block: register port, lane split by mode and bfloat16 fused path
// Functional notes
// - multiply, add, subtract and accumulate results
// - normal: one 19x18 product, 48-bit adder
// - dual: 11x10 and 8x8, 24-bit adders
// - quad: 7x6 and three 4x4, 12-bit adders
// - float: one bfloat16 fused multiply-add
// - 4-bit right shift, lanes follow mode
// - sign setting selects signed or unsigned operands
// - one sign setting for every multiplier
// - operands come from A and B inputs
// - product optionally bypasses the adder
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dmac_defs.svh"
module dmac_top
   import dmac_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic [18:0] A_DATA,
   input  wire logic [17:0] B_DATA,
   input  wire logic [47:0] C_DATA,
   input  wire logic        ENABLE,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   output logic      [47:0] RESULT
);

   // control word and the fields decoded from it
   logic [`DMAC_CTRL_W-1:0] ctrl;        // control register
   dmac_mode_t              mode;        // decoded mode
   logic                    is_signed;   // shared sign selection
   logic                    use_add;     // adder stage in use
   logic                    sub;         // subtract
   logic                    accum;       // accumulate
   logic [3:0]              shift;       // shift amount
   // lane state and what each lane hands back
   dmac_word_t              acc [4];     // registered lane results
   dmac_word_t              lane_next [4]; // next lane results
   dmac_word_t              lane_out [4];  // lane outputs at their result position
   // float path and output assembly
   logic [15:0]             fp_addend;   // float addend
   logic [15:0]             fp_next;     // float result
   dmac_word_t              next_result; // assembled result
   logic [31:0]             next_rdata;  // read mux

   // one connection bundle for each integer lane
   dmac_lane_if lif [4] ();

   // control fields
   assign mode      = dmac_mode_t'(ctrl[`DMAC_MODE_LSB +: 2]);
   // a single sign bit steers every lane alike
   assign is_signed = ctrl[`DMAC_SIGNED_BIT];
   assign use_add   = ctrl[`DMAC_ADD_BIT];
   assign sub       = ctrl[`DMAC_SUB_BIT];
   assign accum     = ctrl[`DMAC_ACC_BIT];
   assign shift     = ctrl[`DMAC_SHIFT_LSB +: 4];

   // field placement of lane j for a mode; idle lanes get zero widths
   // offsets are bit positions in the A, B and result words
   function automatic void lane_geom(
      input  dmac_mode_t m,
      input  int         j,
      output logic [4:0] aoff,
      output logic [4:0] aw,
      output logic [4:0] boff,
      output logic [4:0] bw,
      output logic [5:0] roff,
      output logic [5:0] rw
   );
      // every lane starts idle; the mode opens the ones it uses
      aoff = 5'h00;
      aw   = 5'h00;
      boff = 5'h00;
      bw   = 5'h00;
      roff = 6'h00;
      rw   = 6'h00;
      case (m)
         DMAC_NORMAL: begin
            // one 19 x 18 product, 48-bit adder
            if (j == 0) begin
               // lane 0 spans the whole operands and result
               aw = 5'(`DMAC_A_W);
               bw = 5'(`DMAC_B_W);
               rw = 6'(`DMAC_R_W);
            end
         end
         DMAC_DUAL: begin
            // 11 x 10 in lane 0, 8 x 8 in lane 1, 24 bits each
            if (j == 0) begin
               // low lane takes a[10:0] and b[9:0]
               aw = 5'h0B;
               bw = 5'h0A;
               rw = 6'(`DMAC_DUAL_R_W);
            end else if (j == 1) begin
               // high lane sits just above the low lane's fields
               aoff = 5'h0B;
               aw   = 5'h08;
               boff = 5'h0A;
               bw   = 5'h08;
               roff = 6'(`DMAC_DUAL_R_W);
               rw   = 6'(`DMAC_DUAL_R_W);
            end
         end
         DMAC_QUAD: begin
            // 7 x 6 in lane 0, 4 x 4 in lanes 1 to 3, 12 bits each
            if (j == 0) begin
               // wide lane takes a[6:0] and b[5:0]
               aw = 5'h07;
               bw = 5'h06;
               rw = 6'(`DMAC_QUAD_R_W);
            end else begin
               // nibble lanes stack above it, results every 12 bits
               aoff = 5'(7 + 4 * (j - 1));
               aw   = 5'h04;
               boff = 5'(6 + 4 * (j - 1));
               bw   = 5'h04;
               roff = 6'(`DMAC_QUAD_R_W * j);
               rw   = 6'(`DMAC_QUAD_R_W);
            end
         end
         default: begin
            // float mode leaves the integer lanes idle
            aw = 5'h00;
         end
      endcase
   endfunction : lane_geom

   // bfloat16 multiply followed by add or subtract; denormals flush to zero, truncating
   function automatic logic [15:0] bf16_fma(
      input logic [15:0] a,
      input logic [15:0] b,
      input logic [15:0] c,
      input logic        add_en,
      input logic        sub_en
   );
      // signs of product, addend, larger, smaller and result
      logic               ps;
      logic               cs;
      logic               ls;
      logic               ss;
      logic               rs;
      // mantissas, then exponents with room for the product's sum
      logic [15:0]        pm;
      logic [15:0]        cm;
      logic signed [10:0] pe;
      logic signed [10:0] ce;
      logic signed [10:0] le;
      logic signed [10:0] re;
      logic signed [10:0] diff;
      // aligned mantissas with two bits of headroom
      logic [17:0]        lm;
      logic [17:0]        sm;
      logic [17:0]        sum;
      logic [17:0]        tmp;
      logic [4:0]         lead;
      logic [15:0]        res;
      // product: both mantissas carry 7 fraction bits, product 14
      // subtract is folded into the product's sign
      ps = a[15] ^ b[15] ^ (sub_en & add_en);
      pm = (a[14:7] == 8'h00 || b[14:7] == 8'h00) ? 16'h0000 : {8'h00, 1'b1, a[6:0]} * {8'h00, 1'b1, b[6:0]};
      pe = $signed({3'b000, a[14:7]}) + $signed({3'b000, b[14:7]}) - 11'sd127;
      // addend scaled to the product's 14 fraction bits
      cs = c[15];
      cm = (!add_en || c[14:7] == 8'h00) ? 16'h0000 : {1'b0, 1'b1, c[6:0], 7'h00};
      ce = $signed({3'b000, c[14:7]});
      // order by exponent so the smaller one is aligned down
      if (cm == 16'h0000 || (pm != 16'h0000 && pe >= ce)) begin
         // product is the larger term
         ls = ps;
         ss = cs;
         le = pe;
         lm = {2'b00, pm};
         sm = {2'b00, cm};
         diff = pe - ce;
      end else begin
         // addend is the larger term
         ls = cs;
         ss = ps;
         le = ce;
         lm = {2'b00, cm};
         sm = {2'b00, pm};
         diff = ce - pe;
      end
      // a shift past the width leaves nothing, so clear outright
      sm = (diff > 11'sd17) ? 18'h00000 : (sm >> diff[4:0]);
      // signed magnitude add
      if (ls == ss) begin
         // like signs: magnitudes add
         sum = lm + sm;
         rs  = ls;
      end else if (lm >= sm) begin
         // unlike signs: the larger sets the sign
         sum = lm - sm;
         rs  = ls;
      end else begin
         // aligned smaller term came out bigger
         sum = sm - lm;
         rs  = ss;
      end
      // normalise on the leading one
      lead = 5'h00;
      for (int i = 0; i < 18; i++) begin
         if (sum[i]) lead = 5'(i);
      end
      // result exponent from the leading one's place
      re  = le + $signed({6'h00, lead}) - 11'sd14;
      // move the leading one up to bit 17
      tmp = 18'(sum << (5'd17 - lead));
      if (sum == 18'h00000 || re <= 11'sd0) begin
         // zero sum or underflow flushes to zero
         res = 16'h0000;
      end else if (re >= 11'sd255) begin
         // overflow saturates to infinity
         res = {rs, 8'hFF, 7'h00};
      end else begin
         // hidden bit dropped, fraction truncated
         res = {rs, re[7:0], tmp[16:10]};
      end
      return res;
   endfunction : bf16_fma

   // integer lanes: operands taken from the A and B inputs
   for (genvar j = 0; j < `DMAC_LANES; j++) begin : g_lane
      logic [4:0] aoff; // a field offset
      logic [4:0] aw;   // a field width
      logic [4:0] boff; // b field offset
      logic [4:0] bw;   // b field width
      logic [5:0] roff; // result field offset
      logic [5:0] rw;   // result field width

      // geometry follows the mode
      always_comb begin
         lane_geom(mode, j, aoff, aw, boff, bw, roff, rw);
      end

      // operand fields moved down to each lane's bit 0
      assign lif[j].a_raw     = A_DATA >> aoff;
      assign lif[j].b_raw     = B_DATA >> boff;
      assign lif[j].c_raw     = C_DATA >> roff;
      assign lif[j].acc       = acc[j];
      assign lif[j].aw        = aw;
      assign lif[j].bw        = bw;
      assign lif[j].rw        = rw;
      assign lif[j].is_signed = is_signed;
      assign lif[j].use_add   = use_add;
      assign lif[j].sub       = sub;
      assign lif[j].accum     = accum;
      assign lif[j].shift     = shift;
      // results come back and move up to their field
      assign lane_next[j]     = lif[j].next_acc;
      assign lane_out[j]      = dmac_word_t'(lif[j].shifted << roff);

      // the lane's own arithmetic
      dmac_lane u_lane (
         .lp (lif[j])
      );
   end

   // float path: addend is the C input or the registered result
   assign fp_addend = accum ? acc[0][15:0] : C_DATA[15:0];
   assign fp_next   = bf16_fma(A_DATA[15:0], B_DATA[15:0], fp_addend, use_add, sub);

   // result assembly; idle lanes contribute zero
   always_comb begin
      next_result = '0;
      if (mode == DMAC_FLOAT) begin
         // float result in the low half word
         next_result = {32'h0000_0000, fp_next};
      end else begin
         for (int j = 0; j < `DMAC_LANES; j++) begin
            // lanes own disjoint fields, so or-ing merges them
            next_result = next_result | lane_out[j];
         end
      end
   end

   // control register write
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ctrl <= `DMAC_CTRL_RESET;
      end else if (REG_WR && REG_ADDR == `DMAC_CTRL_ADDR) begin
         // only the control word is writable
         ctrl <= REG_WDATA[`DMAC_CTRL_W-1:0];
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      // result halves are live; read them with ENABLE low
      case (REG_ADDR)
         `DMAC_CTRL_ADDR:   next_rdata = {22'h000000, ctrl};
         `DMAC_RES_LO_ADDR: next_rdata = RESULT[31:0];
         `DMAC_RES_HI_ADDR: next_rdata = {16'h0000, RESULT[47:32]};
         default:           next_rdata = 32'h0000_0000;
      endcase
   end

   // read data stand for the one cycle after the strobe only
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         REG_RDATA <= 32'h0000_0000;
      end else if (REG_RD) begin
         // capture the addressed word for one cycle
         REG_RDATA <= next_rdata;
      end else begin
         // idle bus reads zero
         REG_RDATA <= 32'h0000_0000;
      end
   end

   // registered lane results, cleared by reset, advanced on enable
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         for (int j = 0; j < `DMAC_LANES; j++) begin
            acc[j] <= 48'h0000_0000_0000;
         end
      end else if (ENABLE) begin
         for (int j = 0; j < `DMAC_LANES; j++) begin
            if (mode == DMAC_FLOAT) begin
               // float keeps its result in lane 0, others clear
               acc[j] <= (j == 0) ? {32'h0000_0000, fp_next} : 48'h0000_0000_0000;
            end else begin
               // the unshifted sum is kept for accumulation
               acc[j] <= lane_next[j];
            end
         end
      end
   end

   // registered block output
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         RESULT <= 48'h0000_0000_0000;
      end else if (ENABLE) begin
         // enable low holds the last result
         RESULT <= next_result;
      end
   end

endmodule : dmac_top
`default_nettype wire

// *** tb/dmac_properties.sv ***
// port assertions for the multiply-accumulate block
`timescale 1ns/1ps
`default_nettype none
module dmac_properties
   import dmac_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RESET,
   input wire logic [18:0] A_DATA,
   input wire logic [17:0] B_DATA,
   input wire logic [47:0] C_DATA,
   input wire logic        ENABLE,
   input wire logic [3:0]  REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic [47:0] RESULT
);
   logic        [9:0]  ctrl;    // shadow of the control word
   logic        [9:0]  en_ctrl; // control seen at the last enabled edge
   logic        [47:0] pu;      // unsigned wide product
   logic signed [47:0] ps;      // signed wide product
   logic        [47:0] e_norm;  // wide lane after the shifter
   logic        [47:0] e_dual;  // two split lanes
   logic        [47:0] e_quad;  // four split lanes
   logic        [47:0] e_sub;   // addend minus product

   // track control writes so the datapath checks know the mode
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) ctrl <= 10'h000;
      else if (REG_WR && REG_ADDR == 4'h0) ctrl <= REG_WDATA[9:0];
   end

   // control that steered the previous enabled edge
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) en_ctrl <= 10'h000;
      else if (ENABLE) en_ctrl <= ctrl;
   end

   assign pu     = {29'h0, A_DATA} * {30'h0, B_DATA};
   assign ps     = 48'($signed(A_DATA)) * 48'($signed(B_DATA));
   assign e_norm = pu >> ctrl[9:6];
   assign e_dual = {24'(A_DATA[18:11]) * 24'(B_DATA[17:10]), 24'(A_DATA[10:0]) * 24'(B_DATA[9:0])};
   assign e_quad = {12'(A_DATA[18:15]) * 12'(B_DATA[17:14]), 12'(A_DATA[14:11]) * 12'(B_DATA[13:10]),
                    12'(A_DATA[10:7]) * 12'(B_DATA[9:6]), 12'(A_DATA[6:0]) * 12'(B_DATA[5:0])};
   assign e_sub  = C_DATA - pu;

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   // one enabled operation under a given control word
   sequence op_with(logic [9:0] c);
      ENABLE && ctrl == c;
   endsequence
   // second and later accumulate steps in a row
   sequence acc_step;
      ENABLE && ctrl == 10'h028 && en_ctrl == 10'h028;
   endsequence

   result_hold_a: assert property (!ENABLE |=> $stable(RESULT))
      else $error("result moved without enable");
   reset_clear_a: assert property ($fell(RESET) |-> RESULT == 48'h0 && REG_RDATA == 32'h0)
      else $error("result not clear after reset");
   res_lo_read_a: assert property (REG_RD && REG_ADDR == 4'h4 |=> REG_RDATA == $past(RESULT[31:0]))
      else $error("low result read wrong");
   res_hi_read_a: assert property (REG_RD && REG_ADDR == 4'h8 |=> REG_RDATA == {16'h0, $past(RESULT[47:32])})
      else $error("high result read wrong");
   wide_product_a: assert property (ENABLE && ctrl[5:0] == 6'h00 |=> RESULT == $past(e_norm))
      else $error("wide product wrong");
   signed_product_a: assert property (op_with(10'h004) |=> RESULT == $past(ps))
      else $error("signed product wrong");
   dual_lanes_a: assert property (op_with(10'h001) |=> RESULT == $past(e_dual))
      else $error("dual lanes wrong");
   quad_lanes_a: assert property (op_with(10'h002) |=> RESULT == $past(e_quad))
      else $error("quad lanes wrong");
   addend_sub_a: assert property (op_with(10'h018) |=> RESULT == $past(e_sub))
      else $error("addend minus product wrong");
   acc_step_a: assert property (acc_step |=> RESULT == $past(RESULT) + $past(pu))
      else $error("accumulate step wrong");
endmodule : dmac_properties

bind dmac_top dmac_properties chk_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .A_DATA(A_DATA), .B_DATA(B_DATA),
   .C_DATA(C_DATA), .ENABLE(ENABLE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RESULT(RESULT));
`default_nettype wire

// *** tb/dmac_fabric.sv ***
// fabric logic model feeding operands and clock enable
`timescale 1ns/1ps
`default_nettype none
module dmac_fabric (
   input  wire logic        CORE_CLK,
   output var  logic [18:0] A_DATA,
   output var  logic [17:0] B_DATA,
   output var  logic [47:0] C_DATA,
   output var  logic        ENABLE
);
   // quiet operands at time zero
   initial begin
      A_DATA = 19'h00000;
      B_DATA = 18'h00000;
      C_DATA = 48'h0;
      ENABLE = 1'b0;
   end

   // one enabled edge, then scrambled operands so stale values are never trusted
   task automatic issue(input logic [18:0] a, input logic [17:0] b, input logic [47:0] c);
      @(posedge CORE_CLK);
      ENABLE <= 1'b1;
      A_DATA <= a;
      B_DATA <= b;
      C_DATA <= c;
      @(posedge CORE_CLK);
      ENABLE <= 1'b0;
      A_DATA <= ~a;
      B_DATA <= ~b;
      C_DATA <= ~c;
   endtask : issue
endmodule : dmac_fabric
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the multiply-accumulate block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dmac_pkg::*;
   logic        CORE_CLK;  // 20 MHz core clock
   logic        RESET;     // active high reset
   logic [18:0] A_DATA;    // operand a from the fabric model
   logic [17:0] B_DATA;    // operand b from the fabric model
   logic [47:0] C_DATA;    // addend from the fabric model
   logic        ENABLE;    // clock enable from the fabric model
   logic [3:0]  REG_ADDR;  // register address
   logic [31:0] REG_WDATA; // register write data
   logic        REG_WR;    // write strobe
   logic        REG_RD;    // read strobe
   logic [31:0] REG_RDATA; // read data
   logic [47:0] RESULT;    // datapath result
   logic [31:0] d;         // last read word
   logic [47:0] p;         // widest unsigned product
   int          failures;  // mismatches seen
   int          checks_done; // comparisons made

   dmac_top dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .A_DATA(A_DATA), .B_DATA(B_DATA), .C_DATA(C_DATA),
      .ENABLE(ENABLE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .RESULT(RESULT));
   dmac_fabric fab_u (.CORE_CLK(CORE_CLK), .A_DATA(A_DATA), .B_DATA(B_DATA), .C_DATA(C_DATA), .ENABLE(ENABLE));

   // 50 ns clock
   initial begin
      CORE_CLK = 1'b0;
      forever #25 CORE_CLK = ~CORE_CLK;
   end

   // compare and count
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one-cycle write strobe
   task automatic wr(input logic [3:0] ad, input logic [31:0] v);
      @(posedge CORE_CLK);
      REG_WR    <= 1'b1;
      REG_ADDR  <= ad;
      REG_WDATA <= v;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] ad, output logic [31:0] v);
      @(posedge CORE_CLK);
      REG_RD   <= 1'b1;
      REG_ADDR <= ad;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      #1 v = REG_RDATA;
   endtask : rd

   // set the control word, run one enabled edge, compare the result
   task automatic op(input logic [9:0] c, input logic [18:0] a, input logic [17:0] b, input logic [47:0] cc,
                     input logic [47:0] exp);
      wr(4'h0, {22'h0, c});
      fab_u.issue(a, b, cc);
      #1 check(RESULT, exp);
   endtask : op

   // summary and verdict
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // hang guard, far beyond the roughly 120 cycles of the sequence
   initial begin
      #200us;
      failures++;
      test_done();
   end

   // main sequence
   initial begin
      RESET = 1'b1;
      REG_ADDR = 4'h0;
      REG_WDATA = 32'h0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      failures = 0;
      checks_done = 0;
      p = 48'h7FFFF * 48'h3FFFF;
      repeat (6) @(posedge CORE_CLK);
      RESET <= 1'b0;
      // reset state and refused writes
      rd(4'h0, d);
      check(48'(d), 48'h0);
      wr(4'h4, 32'hFFFFFFFF);
      wr(4'hC, 32'hFFFFFFFF);
      rd(4'h4, d);
      check(48'(d), 48'h0);
      rd(4'hC, d);
      check(48'(d), 48'h0);
      wr(4'h0, 32'h3FF);
      rd(4'h0, d);
      check(48'(d), 48'h3FF);
      // widest mode, addend ignored with adder off, then read back in two halves
      op(10'h000, 19'h7FFFF, 18'h3FFFF, 48'h5, p);
      rd(4'h4, d);
      check(48'(d), {16'h0, p[31:0]});
      rd(4'h8, d);
      check(48'(d), {32'h0, p[47:32]});
      for (int s = 5; s < 16; s += 5) op(10'(s << 6), 19'h7FFFF, 18'h3FFFF, 48'h0, p >> s);
      // sign setting shared by the wide lane and both dual lanes
      op(10'h004, 19'h7FFFF, 18'h00002, 48'h0, 48'hFFFFFFFFFFFE);
      op(10'h104, 19'h7FFFF, 18'h00010, 48'h0, 48'hFFFFFFFFFFFF);
      op(10'h005, {8'hFF, 11'h7FF}, {8'h03, 10'h002}, 48'h0, {24'hFFFFFD, 24'hFFFFFE});
      // split modes at full scale
      op(10'h001, 19'h7FFFF, 18'h3FFFF, 48'h0, {24'hFF * 24'hFF, 24'h7FF * 24'h3FF});
      op(10'h002, 19'h7FFFF, 18'h3FFFF, 48'h0, {12'hE1, 12'hE1, 12'hE1, 12'hF41});
      op(10'h0C2, 19'h7FFFF, 18'h3FFFF, 48'h0, {12'h01C, 12'h01C, 12'h01C, 12'h1E8});
      // split modes with each lane's own addend field
      op(10'h009, {8'h02, 11'h003}, {8'h03, 10'h004}, {24'h10, 24'h20}, {24'h16, 24'h2C});
      op(10'h00A, 19'h00001, 18'h00001, {12'h3, 12'h2, 12'h1, 12'hFFF}, {12'h3, 12'h2, 12'h1, 12'h0});
      // addend minus product, with wrap
      op(10'h018, 19'h00003, 18'h00005, 48'd100, 48'd85);
      op(10'h018, 19'h00001, 18'h00001, 48'h0, 48'hFFFFFFFFFFFF);
      // accumulate onto own result, addend ignored
      op(10'h008, 19'h00000, 18'h00000, 48'h0, 48'h0);
      op(10'h028, 19'h00003, 18'h00004, 48'hFFF, 48'd12);
      op(10'h028, 19'h00003, 18'h00004, 48'hFFF, 48'd24);
      op(10'h038, 19'h00005, 18'h00001, 48'hFFF, 48'd19);
      repeat (5) @(posedge CORE_CLK);
      #1 check(RESULT, 48'd19);
      // fused float multiply with add and subtract
      op(10'h00B, 19'h03FC0, 18'h04000, 48'h3F80, 48'h4080);
      op(10'h02B, 19'h03FC0, 18'h04000, 48'h0, 48'h40E0);
      op(10'h01B, 19'h03FC0, 18'h04000, 48'h3F80, 48'h0C000);
      // reset in mid-run clears result and control
      @(posedge CORE_CLK);
      RESET <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      RESET <= 1'b0;
      rd(4'h4, d);
      check(48'(d), 48'h0);
      rd(4'h0, d);
      check(48'(d), 48'h0);
      check(RESULT, 48'h0);
      test_done();
   end
endmodule : tb
`default_nettype wire
